// >>> sbc_defines.svh
// Offsets, field positions, codes and timing for the supervisory block
// Function
// - Reset-length field picks cold-start pulse: 20, 10, 3.6 or 1 ms least.
// - Supply below selected threshold forces Reset mode.
// - External low on the reset pin forces Reset mode.
// - Window watchdog overflow or early trigger forces Reset mode.
// - Timeout watchdog overflow with failure pending forces Reset mode.
// - Watchdog control write attempt in Normal mode forces Reset mode.
// - Leaving Off or Overtemp always passes through Reset mode; battery power-off takes Overtemp straight to Off.
// - Over-temperature outside Off: Overtemp, pin low, supply and transceiver off.
// - Temperature below release leaves Overtemp to Standby via Reset.
// - Temperature above warning sets warning status and warning event.
// - Battery below power-off level enters Off mode.
// - Start-up delay after battery power-on: Off to Reset, power-on event set.
// - Threshold field selects reset level 90, 80, 70 or 60 percent.
// - Threshold field loads from non-volatile start-up setting at power-up.
// - Enabled undervoltage event captured when supply drops below 90 percent.
// - Status bit 0 shows supply below 90 percent; powers up at 0.
// - Bus biased mid-level in Active or Listen-only modes.
// - Offline biases mid while bus active, ground after silence timeout.
// - Mode field applies only in Normal; Standby forces Offline or Offline Bias.
// - Field 01 drops transceiver offline when supply below 90 percent.
// - Field 10 stays active until reset threshold, then Reset and offline.
// - Active only in Normal, field 01 or 10, supply above its threshold.
// - Any system reset enters Reset mode and pulses the reset pin low.
// - Warm resets without undervoltage use the 1 ms shortest pulse.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define CLK_MHZ       200
`define RST_T0_US     20000
`define RST_T1_US     10000
`define RST_T2_US     3600
`define RST_T3_US     1000
`define STARTUP_US    1000
`define SILENCE_US    1000

`define REG_MODE_CTRL 8'h01
`define REG_TEMP_STAT 8'h03
`define REG_SUP_CTRL  8'h10
`define REG_SUP_STAT  8'h1b
`define REG_EV_EN     8'h1c
`define REG_TRX_CTRL  8'h20
`define REG_TRX_STAT  8'h22
`define REG_EVENTS    8'h61
`define REG_STARTUP   8'h73

`define RLC_HI        5
`define RLC_LO        4
`define RLC_RST       2'h0
`define RLC_SHORTEST  2'h3
`define THR_90        2'h0
`define EV_PO         0
`define EV_OTW        1
`define EV_UV         2
`define TS_CTS        7
`define TS_SIL        3

`define MC_OFF        3'h0
`define MC_RESET      3'h3
`define MC_STANDBY    3'h4
`define MC_OVERTEMP   3'h5
`define MC_NORMAL     3'h7
`define CMC_OFFLINE   2'h0
`define CMC_ACT_UV    2'h1
`define CMC_ACT       2'h2
`define CMC_LISTEN    2'h3

`endif

// >>> sbc_pkg.sv
// Types shared by the supervisory block
package sbc_pkg;
   typedef enum logic [2:0] {
      MODE_OFF, MODE_RESET, MODE_STANDBY, MODE_NORMAL, MODE_OVERTEMP
   } chip_mode_e;
   typedef enum logic [2:0] {
      TRX_OFF, TRX_OFFLINE, TRX_BIAS, TRX_LISTEN, TRX_ACTIVE
   } trx_mode_e;
   typedef logic [27:0] cnt_t;
   typedef struct packed {
      chip_mode_e mode;
      trx_mode_e  trx;
      cnt_t       cnt;
      cnt_t       silCnt;
      logic       silent;
      logic       cold;
      logic       done;
      logic       pinDrv;
      logic       supEn;
      logic       loaded;
      logic [1:0] thr;
      logic [1:0] reset_length_select;
      logic [1:0] transceiver_mode_select;
      logic       uvEn;
      logic       evPo;
      logic       evOtw;
      logic       evUv;
      logic       v1s;
      logic       overtemp_warning_status;
      logic [31:0] rdata;
   } state_s;
endpackage : sbc_pkg

// >>> sbc_reset_supply_can_mode.sv
// Reset sources, chip mode, supply supervision and transceiver mode choice
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module sbc_reset_supply_can_mode
   import sbc_pkg::*;
#(
   parameter int unsigned RST_CYC0    = `RST_T0_US * `CLK_MHZ,
   parameter int unsigned RST_CYC1    = `RST_T1_US * `CLK_MHZ,
   parameter int unsigned RST_CYC2    = `RST_T2_US * `CLK_MHZ,
   parameter int unsigned RST_CYC3    = `RST_T3_US * `CLK_MHZ,
   parameter int unsigned STARTUP_CYC = `STARTUP_US * `CLK_MHZ,
   parameter int unsigned SILENCE_CYC = `SILENCE_US * `CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  supplyBelow,
   input  wire logic [1:0]  startupThresholdDefault,
   input  wire logic        resetPinNIn,
   output logic             resetPinNOut,
   output logic             resetPinNOe,
   input  wire logic        wdWindowMode,
   input  wire logic        wdTimeoutMode,
   input  wire logic        wdOverflow,
   input  wire logic        wdEarlyTrigger,
   input  wire logic        watchdogFailurePending,
   input  wire logic        wdCtrlWriteAttempt,
   input  wire logic        tempOverAct,
   input  wire logic        tempBelowRel,
   input  wire logic        tempOverWarn,
   input  wire logic        batPowerOff,
   input  wire logic        batPowerOn,
   input  wire logic        busActivity,
   output chip_mode_e       chipMode,
   output trx_mode_e        trxMode,
   output logic             busBiasMid,
   output logic             supplyEnable
);

   localparam int unsigned CW = $bits(cnt_t);

   if (RST_CYC0 == 0 || RST_CYC0 >= (64'd1 << CW) ||
       RST_CYC1 == 0 || RST_CYC1 >= (64'd1 << CW) ||
       RST_CYC2 == 0 || RST_CYC2 >= (64'd1 << CW) ||
       RST_CYC3 == 0 || RST_CYC3 >= (64'd1 << CW) ||
       STARTUP_CYC == 0 || STARTUP_CYC >= (64'd1 << CW) ||
       SILENCE_CYC == 0 || SILENCE_CYC >= (64'd1 << CW)) begin : g_chk
      $error("cycle count parameter out of counter range");
   end

   // pulse width: warm resets always take the shortest
   function automatic cnt_t rstLen(input logic cold, input logic [1:0] sel);
      logic [1:0] s;
      s = cold ? sel : `RLC_SHORTEST;
      case (s)
         2'h0:    rstLen = cnt_t'(RST_CYC0);
         2'h1:    rstLen = cnt_t'(RST_CYC1);
         2'h2:    rstLen = cnt_t'(RST_CYC2);
         default: rstLen = cnt_t'(RST_CYC3);
      endcase
   endfunction : rstLen

   function automatic logic isMapped(input logic [11:0] a);
      logic [7:0] i;
      i = a[9:2];
      isMapped = (a[11:10] == 2'h0) &&
         (i == `REG_MODE_CTRL || i == `REG_TEMP_STAT ||
          i == `REG_SUP_CTRL  || i == `REG_SUP_STAT  ||
          i == `REG_EV_EN     || i == `REG_TRX_CTRL  ||
          i == `REG_TRX_STAT  || i == `REG_EVENTS    ||
          i == `REG_STARTUP);
   endfunction : isMapped

   function automatic logic [2:0] modeCode(input chip_mode_e m);
      case (m)
         MODE_RESET:    modeCode = `MC_RESET;
         MODE_STANDBY:  modeCode = `MC_STANDBY;
         MODE_NORMAL:   modeCode = `MC_NORMAL;
         MODE_OVERTEMP: modeCode = `MC_OVERTEMP;
         default:       modeCode = `MC_OFF;
      endcase
   endfunction : modeCode

   state_s r;
   state_s n;

   logic [7:0] idx;
   logic       wr;
   logic       selBelow;
   logic       belowWarn;
   logic       wdFault;
   logic       reconf;
   logic       extLow;

   assign idx       = paddr[9:2];
   assign wr        = psel && penable && pwrite && isMapped(paddr);
   // selected level; index 0 is the 90 percent comparator
   assign selBelow  = supplyBelow[r.thr];
   assign belowWarn = supplyBelow[`THR_90];
   assign wdFault   = (wdWindowMode && (wdOverflow || wdEarlyTrigger)) ||
                      (wdTimeoutMode && wdOverflow && watchdogFailurePending);
   // reconfiguration attempt only counts in Normal
   assign reconf    = wdCtrlWriteAttempt && r.mode == MODE_NORMAL;
   // pin is released in Standby, Normal and Reset after the pulse, so a low there is external
   assign extLow    = !resetPinNIn;

   always_comb begin
      n = r;
      // threshold taken from the start-up setting after power-up
      if (!r.loaded) begin
         n.thr    = startupThresholdDefault;
         n.loaded = 1'b1;
      end

      if (wr) begin
         case (idx)
            `REG_MODE_CTRL: begin
               if (pwdata[2:0] == `MC_NORMAL && r.mode == MODE_STANDBY)
                  n.mode = MODE_NORMAL;
               else if (pwdata[2:0] == `MC_STANDBY && r.mode == MODE_NORMAL)
                  n.mode = MODE_STANDBY;
            end
            `REG_SUP_CTRL: n.thr  = pwdata[1:0];
            `REG_EV_EN:    n.uvEn = pwdata[0];
            `REG_TRX_CTRL: n.transceiver_mode_select  = pwdata[1:0];
            `REG_STARTUP:  n.reset_length_select  = pwdata[`RLC_HI:`RLC_LO];
            default: ;
         endcase
      end

      // Write one to clear; a new event in the same cycle wins
      if (wr && idx == `REG_EVENTS) begin
         n.evPo  = r.evPo  && !pwdata[`EV_PO];
         n.evOtw = r.evOtw && !pwdata[`EV_OTW];
         n.evUv  = r.evUv  && !pwdata[`EV_UV];
      end

      // supply status follows the 90 percent comparator
      n.v1s = belowWarn;
      // capture on the falling crossing when enabled
      if (r.uvEn && belowWarn && !r.v1s)
         n.evUv = 1'b1;

      // warning is not monitored in Off
      n.overtemp_warning_status = tempOverWarn && r.mode != MODE_OFF;
      if (n.overtemp_warning_status && !r.overtemp_warning_status)
         n.evOtw = 1'b1;

      if (busActivity) begin
         n.silCnt = '0;
         n.silent = 1'b0;
      end else if (r.silCnt >= cnt_t'(SILENCE_CYC - 1)) begin
         n.silent = 1'b1;
      end else begin
         n.silCnt = r.silCnt + cnt_t'(1);
      end

      case (r.mode)
         MODE_OFF: begin
            if (!batPowerOn) begin
               n.cnt = '0;
            // start-up delay, then Reset with power-on event
            end else if (r.cnt >= cnt_t'(STARTUP_CYC - 1)) begin
               n.mode   = MODE_RESET;
               n.cnt    = '0;
               n.done   = 1'b0;
               n.cold   = 1'b1;
               n.evPo   = 1'b1;
               n.thr    = startupThresholdDefault;
               n.silent = 1'b1;
            end else begin
               n.cnt = r.cnt + cnt_t'(1);
            end
         end
         MODE_RESET: begin
            if (selBelow) begin
               // Undervoltage inside Reset turns it into a cold start
               n.cnt  = '0;
               n.done = 1'b0;
               n.cold = 1'b1;
            end else if (!r.done) begin
               if (r.cnt >= rstLen(r.cold, r.reset_length_select) - cnt_t'(1))
                  n.done = 1'b1;
               else
                  n.cnt = r.cnt + cnt_t'(1);
            end else if (extLow) begin
               // pin still held low outside: restart as warm
               n.cnt  = '0;
               n.done = 1'b0;
               n.cold = 1'b0;
            end else begin
               n.mode = MODE_STANDBY;
               n.cold = 1'b0;
            end
         end
         MODE_STANDBY, MODE_NORMAL: begin
            if (selBelow || extLow || wdFault || reconf) begin
               n.mode = MODE_RESET;
               n.cnt  = '0;
               n.done = 1'b0;
               n.cold = selBelow;
            end
         end
         MODE_OVERTEMP: begin
            // release goes through a cold Reset
            if (tempBelowRel) begin
               n.mode   = MODE_RESET;
               n.cnt    = '0;
               n.done   = 1'b0;
               n.cold   = 1'b1;
               n.silent = 1'b1;
            end
         end
         default: n.mode = MODE_OFF;
      endcase

      if (batPowerOff) begin
         n.mode = MODE_OFF;
         n.cnt  = '0;
      end else if (tempOverAct && r.mode != MODE_OFF) begin
         n.mode = MODE_OVERTEMP;
      end

      n.pinDrv = n.mode == MODE_OFF || n.mode == MODE_OVERTEMP ||
                 (n.mode == MODE_RESET && !n.done);
      n.supEn  = n.mode != MODE_OVERTEMP;

      // field only steers the transceiver in Normal
      case (n.mode)
         MODE_OFF, MODE_OVERTEMP: n.trx = TRX_OFF;
         MODE_NORMAL: begin
            case (n.transceiver_mode_select)
               `CMC_ACT_UV: n.trx = belowWarn ? TRX_BIAS : TRX_ACTIVE;
               `CMC_ACT:    n.trx = selBelow ? TRX_BIAS : TRX_ACTIVE;
               `CMC_LISTEN: n.trx = TRX_LISTEN;
               default:     n.trx = TRX_BIAS;
            endcase
         end
         default: n.trx = TRX_BIAS;
      endcase
      // fall to ground bias once the bus is silent
      if (n.trx == TRX_BIAS && n.silent)
         n.trx = TRX_OFFLINE;

      // Read data captured in setup so the access phase needs no wait
      n.rdata = '0;
      if (psel && !penable) begin
         case (idx)
            `REG_MODE_CTRL: n.rdata[2:0] = modeCode(r.mode);
            `REG_TEMP_STAT: n.rdata[0]   = r.overtemp_warning_status;
            `REG_SUP_CTRL:  n.rdata[1:0] = r.thr;
            `REG_SUP_STAT:  n.rdata[0]   = r.v1s;
            `REG_EV_EN:     n.rdata[0]   = r.uvEn;
            `REG_TRX_CTRL:  n.rdata[1:0] = r.transceiver_mode_select;
            `REG_TRX_STAT: begin
               n.rdata[`TS_CTS] = r.trx == TRX_ACTIVE;
               n.rdata[`TS_SIL] = r.silent;
            end
            `REG_EVENTS: begin
               n.rdata[`EV_PO]  = r.evPo;
               n.rdata[`EV_OTW] = r.evOtw;
               n.rdata[`EV_UV]  = r.evUv;
            end
            `REG_STARTUP:   n.rdata[`RLC_HI:`RLC_LO] = r.reset_length_select;
            default: ;
         endcase
         if (paddr[11:10] != 2'h0)
            n.rdata = '0;
      end else begin
         n.rdata = r.rdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r        <= '0;
         r.mode   <= MODE_OFF;
         r.trx    <= TRX_OFF;
         r.pinDrv <= 1'b1;
         r.supEn  <= 1'b1;
         r.silent <= 1'b1;
         r.reset_length_select    <= `RLC_RST;
         r.transceiver_mode_select    <= `CMC_OFFLINE;
      end else begin
         r <= n;
      end
   end

   assign prdata       = r.rdata;
   assign pready       = 1'b1;
   assign pslverr      = psel && penable && !isMapped(paddr);
   assign resetPinNOut = 1'b0;
   assign resetPinNOe  = r.pinDrv;
   assign chipMode     = r.mode;
   assign trxMode      = r.trx;
   assign busBiasMid   = r.trx == TRX_ACTIVE || r.trx == TRX_LISTEN ||
                         r.trx == TRX_BIAS;
   assign supplyEnable = r.supEn;

   // Helper: cycles spent driving the pulse since the last restart
   cnt_t lowCnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         lowCnt <= '0;
      else if (r.mode == MODE_RESET && !r.done && !selBelow)
         lowCnt <= lowCnt + cnt_t'(1);
      else
         lowCnt <= '0;
   end

   logic calm;
   assign calm = !batPowerOff && !tempOverAct;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence leaveOtp_s;
      r.mode == MODE_OVERTEMP && tempBelowRel && calm;
   endsequence
   sequence coldReset_s;
      r.mode == MODE_RESET && r.cold && r.trx == TRX_OFFLINE && r.pinDrv;
   endsequence

   pulse_len_a: assert property (
      $rose(r.done) && r.mode == MODE_RESET |->
         lowCnt == rstLen(r.cold, r.reset_length_select))
      else $error("reset pulse length differs from selection");

   uv_reset_a: assert property (
      r.mode == MODE_NORMAL && selBelow && calm |=>
         r.mode == MODE_RESET && r.cold && resetPinNOe)
      else $error("undervoltage did not start a cold reset");

   ext_reset_a: assert property (
      (r.mode == MODE_STANDBY || r.mode == MODE_NORMAL) && !resetPinNIn &&
      !selBelow && calm |=>
         r.mode == MODE_RESET && !r.cold ##0 resetPinNOe [*2])
      else $error("external reset not followed");

   wd_window_a: assert property (
      r.mode == MODE_NORMAL && wdWindowMode && wdEarlyTrigger && calm
         |=> r.mode == MODE_RESET)
      else $error("early trigger did not reset");

   wd_timeout_a: assert property (
      r.mode == MODE_NORMAL && wdTimeoutMode && wdOverflow &&
      !watchdogFailurePending && !wdWindowMode && !wdCtrlWriteAttempt &&
      !selBelow && resetPinNIn && calm |=> r.mode == MODE_NORMAL)
      else $error("single timeout overflow reset the chip");

   wd_reconf_a: assert property (
      r.mode == MODE_NORMAL && wdCtrlWriteAttempt && calm |=>
         r.mode == MODE_RESET)
      else $error("watchdog reconfiguration in Normal ignored");

   otp_enter_a: assert property (
      r.mode != MODE_OFF && tempOverAct && !batPowerOff |=>
         r.mode == MODE_OVERTEMP && resetPinNOe && !supplyEnable &&
         trxMode == TRX_OFF)
      else $error("overtemperature shutdown incomplete");

   otp_leave_a: assert property (
      leaveOtp_s |=> coldReset_s)
      else $error("overtemp release did not pass through reset");

   power_off_a: assert property (
      batPowerOff |=> r.mode == MODE_OFF && trxMode == TRX_OFF)
      else $error("power-off not entered");

   power_on_a: assert property (
      r.mode == MODE_OFF && batPowerOn && !batPowerOff &&
      r.cnt == cnt_t'(STARTUP_CYC - 1) |=> r.mode == MODE_RESET && r.evPo)
      else $error("start-up delay did not end in reset");

   otw_event_a: assert property (
      r.mode == MODE_NORMAL && tempOverWarn && !r.overtemp_warning_status |=> r.overtemp_warning_status && r.evOtw)
      else $error("warning not captured");

   uv_event_a: assert property (
      r.uvEn && belowWarn && !r.v1s |=> r.evUv && r.v1s)
      else $error("undervoltage event lost");

   v1s_stat_a: assert property (
      ##1 r.v1s == $past(belowWarn))
      else $error("supply status bit stale");

   trx_active_a: assert property (
      trxMode == TRX_ACTIVE |-> r.mode == MODE_NORMAL &&
         ((r.transceiver_mode_select == `CMC_ACT_UV && !$past(belowWarn)) ||
          (r.transceiver_mode_select == `CMC_ACT && !$past(selBelow))))
      else $error("transceiver active without permission");

   standby_trx_a: assert property (
      r.mode == MODE_STANDBY |-> trxMode == TRX_OFFLINE ||
         trxMode == TRX_BIAS)
      else $error("transceiver not offline in Standby");

endmodule : sbc_reset_supply_can_mode

`default_nettype wire

// >>> sbc_host_model.sv
// Host microcontroller model on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model #(
   parameter int MIN_PULL = 4
) (
   input  wire logic clk,
   input  wire logic pullReq,
   input  wire logic devOe,
   input  wire logic devOut,
   output logic      pinLevel
);
   int pullCnt_r = 0;
   always_ff @(posedge clk) begin
      pullCnt_r <= pullReq ? MIN_PULL : (pullCnt_r > 0 ? pullCnt_r - 1 : 0);
   end
   // Pull-up wins unless a party pulls low
   assign pinLevel = !((devOe && !devOut) || pullCnt_r > 0);
endmodule : sbc_host_model
`default_nettype wire

// >>> sbc_reset_supply_can_mode_bench.sv
// Self-checking bench for the supervisory block
`timescale 1ns/1ps
`default_nettype none
module sbc_reset_supply_can_mode_bench;
   import sbc_pkg::*;
   localparam int C0 = 40, C1 = 30, C2 = 20, C3 = 10, SU = 8, SI = 8;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] paddr;
   logic [3:0]  supplyBelow;
   logic [1:0]  startupThresholdDefault, thr;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, slv, pullReq;
   logic        resetPinNIn, resetPinNOut, resetPinNOe, busBiasMid, supplyEnable;
   logic        wdWindowMode, wdTimeoutMode, wdOverflow, wdEarlyTrigger;
   logic        watchdogFailurePending, wdCtrlWriteAttempt, tempOverAct, tempBelowRel;
   logic        tempOverWarn, batPowerOff, batPowerOn, busActivity;
   chip_mode_e  chipMode;
   trx_mode_e   trxMode;
   int          err_total = 0, n_checks = 0;

   sbc_reset_supply_can_mode #(.RST_CYC0(C0), .RST_CYC1(C1), .RST_CYC2(C2), .RST_CYC3(C3),
      .STARTUP_CYC(SU), .SILENCE_CYC(SI)) sbc_reset_supply_can_mode_inst (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supplyBelow(supplyBelow), .startupThresholdDefault(startupThresholdDefault),
      .resetPinNIn(resetPinNIn), .resetPinNOut(resetPinNOut), .resetPinNOe(resetPinNOe),
      .wdWindowMode(wdWindowMode), .wdTimeoutMode(wdTimeoutMode), .wdOverflow(wdOverflow),
      .wdEarlyTrigger(wdEarlyTrigger), .watchdogFailurePending(watchdogFailurePending),
      .wdCtrlWriteAttempt(wdCtrlWriteAttempt), .tempOverAct(tempOverAct),
      .tempBelowRel(tempBelowRel), .tempOverWarn(tempOverWarn), .batPowerOff(batPowerOff),
      .batPowerOn(batPowerOn), .busActivity(busActivity), .chipMode(chipMode),
      .trxMode(trxMode), .busBiasMid(busBiasMid), .supplyEnable(supplyEnable));
   sbc_host_model sbc_host_model_inst (.clk(clk), .pullReq(pullReq), .devOe(resetPinNOe),
      .devOut(resetPinNOut), .pinLevel(resetPinNIn));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; byte address is four times the register index
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      slv     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         report_and_stop();
      end
      @(posedge clk);
   endtask : apb

   task automatic waitMode(input chip_mode_e m);
      int n;
      for (n = 0; n < 400 && chipMode !== m; n++) @(posedge clk);
      chk(32'(chipMode), 32'(m));
      if (chipMode !== m) report_and_stop();
   endtask : waitMode

   task automatic waitTrx(input trx_mode_e t);
      int n;
      for (n = 0; n < 40 && trxMode !== t; n++) @(posedge clk);
      chk(32'(trxMode), 32'(t));
      if (trxMode !== t) report_and_stop();
   endtask : waitTrx

   // Pin held low for the expected count, then Standby
   task automatic rstPulse(input int exp);
      int n;
      waitMode(MODE_RESET);
      supplyBelow <= 4'h0;
      for (n = 0; n < 200 && resetPinNOe === 1'b1; n++) @(posedge clk);
      chk(32'(n >= exp - 2 && n <= exp + 2), 32'h1);
      waitMode(MODE_STANDBY);
   endtask : rstPulse

   task automatic toNormal;
      apb(1'b1, 8'h01, 32'h7);
      waitMode(MODE_NORMAL);
   endtask : toNormal

   function automatic int coldLen(input logic [1:0] c);
      return c == 2'h0 ? C0 : c == 2'h1 ? C1 : c == 2'h2 ? C2 : C3;
   endfunction : coldLen

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      void'($urandom(32'h110ca1b3));
      {nrst, psel, penable, pwrite, paddr, pwdata, supplyBelow, pullReq} = '0;
      {wdWindowMode, wdTimeoutMode, wdOverflow, wdEarlyTrigger} = '0;
      {watchdogFailurePending, wdCtrlWriteAttempt, tempOverAct, tempBelowRel} = '0;
      {tempOverWarn, batPowerOff, batPowerOn, busActivity} = '0;
      startupThresholdDefault = 2'($urandom());
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h10, 0);
      chk(rd & 32'h3, 32'(startupThresholdDefault));
      apb(1'b0, 8'h1b, 0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h73, 0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h7f, $urandom());
      chk(32'(slv), 32'h1);
      $display("test reset values done");
      batPowerOn <= 1'b1;
      repeat (SU - 2) @(posedge clk);
      chk(32'(chipMode), 32'(MODE_OFF));
      rstPulse(C0);
      apb(1'b0, 8'h61, 0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, 8'h61, 32'h7);
      $display("test power-on done");
      for (int c = 0; c < 4; c++) begin
         thr = 2'($urandom());
         apb(1'b1, 8'h73, 32'(c << 4));
         apb(1'b1, 8'h10, 32'(thr));
         toNormal();
         supplyBelow <= 4'((5'h1 << thr) - 5'h1);
         repeat (4) @(posedge clk);
         chk(32'(chipMode), 32'(MODE_NORMAL));
         supplyBelow <= 4'((5'h2 << thr) - 5'h1);
         rstPulse(coldLen(2'(c)));
      end
      apb(1'b1, 8'h73, 0);
      $display("test cold resets done");
      for (int k = 0; k < 6; k++) begin
         toNormal();
         case (k)
            0: pullReq <= 1'b1;
            1: begin
               wdWindowMode <= 1'b1;
               wdOverflow   <= 1'b1;
            end
            2: begin
               wdWindowMode   <= 1'b1;
               wdEarlyTrigger <= 1'b1;
            end
            3, 5: begin
               wdTimeoutMode          <= 1'b1;
               watchdogFailurePending <= (k == 3);
               wdOverflow             <= 1'b1;
            end
            default: wdCtrlWriteAttempt <= 1'b1;
         endcase
         @(posedge clk);
         {pullReq, wdOverflow, wdEarlyTrigger, wdCtrlWriteAttempt} <= '0;
         if (k == 5) begin
            repeat (4) @(posedge clk);
            chk(32'(chipMode), 32'(MODE_NORMAL));
         end
         else rstPulse(C3);
         {wdWindowMode, wdTimeoutMode, watchdogFailurePending} <= '0;
      end
      $display("test warm resets done");
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, 8'h20, 32'(c));
         waitTrx(c == 0 ? TRX_OFFLINE : c == 3 ? TRX_LISTEN : TRX_ACTIVE);
         chk(32'(busBiasMid), 32'(c != 0));
      end
      apb(1'b1, 8'h20, 0);
      waitTrx(TRX_OFFLINE);
      busActivity <= 1'b1;
      @(posedge clk);
      busActivity <= 1'b0;
      waitTrx(TRX_BIAS);
      chk(32'(busBiasMid), 32'h1);
      waitTrx(TRX_OFFLINE);
      $display("test transceiver modes done");
      apb(1'b1, 8'h1c, 1);
      apb(1'b1, 8'h10, 3);
      apb(1'b1, 8'h20, 1);
      waitTrx(TRX_ACTIVE);
      supplyBelow <= 4'h1;
      repeat (4) @(posedge clk);
      chk(32'(trxMode == TRX_ACTIVE), 32'h0);
      apb(1'b0, 8'h1b, 0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h61, 0);
      chk(rd & 32'h4, 32'h4);
      apb(1'b1, 8'h20, 2);
      waitTrx(TRX_ACTIVE);
      chk(32'(chipMode), 32'(MODE_NORMAL));
      apb(1'b0, 8'h22, 0);
      chk(rd, 32'h88);
      apb(1'b0, 8'h01, 0);
      chk(rd, 32'h7);
      supplyBelow <= 4'h0;
      // Status bit follows the comparator one edge late
      @(posedge clk);
      apb(1'b0, 8'h1b, 0);
      chk(rd, 32'h0);
      $display("test undervoltage warning done");
      tempOverWarn <= 1'b1;
      tempOverAct  <= 1'b1;
      waitMode(MODE_OVERTEMP);
      chk({resetPinNOe, supplyEnable, 29'h0, trxMode == TRX_OFF}, 32'h80000001);
      apb(1'b0, 8'h03, 0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b0, 8'h61, 0);
      chk(rd & 32'h2, 32'h2);
      {tempOverAct, tempOverWarn, tempBelowRel} <= 3'b001;
      rstPulse(C0);
      tempBelowRel <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(trxMode == TRX_ACTIVE), 32'h0);
      $display("test overtemperature done");
      batPowerOff <= 1'b1;
      waitMode(MODE_OFF);
      $display("test power-off done");
      report_and_stop();
   end
endmodule : sbc_reset_supply_can_mode_bench
`default_nettype wire
